// File: core/pelf_top.sv
// pelf_top: pin function select for port e pins 11 to 0, apb registers.
// assumes: peripherals and pins synchronous to clk_i; the pad ring
// resolves each pin from its output and enable.
`timescale 1ns/1ps
module pelf_top (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // variant and debug strap
    input wire logic flash_variant_i,
    input wire logic debug_mode_pin_i,
    // pins
    input wire logic [11:0] port_pin_in_i,
    output logic [11:0] port_pin_out_o,
    output logic [11:0] port_pin_oe_o,
    // general port
    input wire logic [11:0] gport_out_i,
    input wire logic [11:0] gport_oe_i,
    output logic [11:0] gport_in_o,
    // timer channels, pin order 11..0: 3d 3c 3b 3a 2b 2a 1b 1a 0d 0c 0b 0a
    input wire logic [11:0] timer_out_i,
    input wire logic [11:0] timer_oe_i,
    output logic [11:0] timer_in_o,
    // serial units
    output logic serial3_receive_o,
    input wire logic serial3_transmit_i,
    input wire logic serial3_clock_out_i,
    input wire logic serial3_clock_oe_i,
    output logic serial3_clock_in_o,
    output logic serial2_receive_o,
    input wire logic serial2_transmit_i,
    input wire logic serial2_clock_out_i,
    input wire logic serial2_clock_oe_i,
    output logic serial2_clock_in_o,
    // dma
    input wire logic dma1_acknowledge_i,
    input wire logic dma0_acknowledge_i,
    output logic dma1_request_o,
    output logic dma0_request_o,
    // trace unit
    input wire logic [3:0] trace_data_out_i,
    input wire logic [3:0] trace_data_oe_i,
    output logic [3:0] trace_data_in_o,
    output logic trace_reset_o,
    output logic trace_mode_sel_o,
    input wire logic trace_clock_out_i,
    input wire logic trace_clock_oe_i,
    output logic trace_clock_in_o,
    // boundary scan
    input wire logic scan_tdo_i,
    output logic scan_tdi_o,
    output logic scan_trst_o,
    output logic scan_tms_o
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0] ctrl1_q, ctrl1_d; // pins 11..8 modes
    logic [15:0] ctrl2_q, ctrl2_d; // pins 7..0 modes
    logic [31:0] rdata_q, rdata_d;
    logic ready_q, ready_d;
    logic err_q, err_d;
    pelf_pkg::pelf_bus_e bus_q, bus_d;
    logic dbg_q, dbg_d; // registered debug mode
    logic [23:0] eff_mode; // 2 bits per pin; pins 7..0 (bits 15..0) read by the status word

    // mode field of pin n from the two control words
    function automatic logic [1:0] pin_mode(input logic [15:0] c1,
                                            input logic [15:0] c2,
                                            input int n);
        logic [1:0] m;
        m = 2'h0;
        if (n >= pelf_pkg::PINS_PER_REG) begin
            m = c1[(n - pelf_pkg::PINS_PER_REG) * pelf_pkg::FIELD_W +: 2];
        end else begin
            m = c2[n * pelf_pkg::FIELD_W +: 2];
        end
        return m;
    endfunction

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    // one-wait answer: setup, access, pready registered high in the cycle after the first access cycle
    logic access;
    assign access = psel_i && penable_i && (bus_q == pelf_pkg::PELF_IDLE);
    always_comb begin
        ctrl1_d = ctrl1_q;
        ctrl2_d = ctrl2_q;
        rdata_d = rdata_q;
        ready_d = 1'b0;
        err_d = 1'b0;
        bus_d = pelf_pkg::PELF_IDLE;
        dbg_d = debug_mode_pin_i;
        if (access) begin
            ready_d = 1'b1;
            bus_d = pelf_pkg::PELF_DONE;
            rdata_d = 32'h0000_0000;
            if (paddr_i == pelf_pkg::CTRL_1_OFS) begin
                if (pwrite_i) begin
                    ctrl1_d = pwdata_i[15:0] & pelf_pkg::CTRL_1_MASK;
                end else begin
                    rdata_d = {16'h0000, ctrl1_q};
                end
            end else if (paddr_i == pelf_pkg::CTRL_2_OFS) begin
                if (pwrite_i) begin
                    ctrl2_d = pwdata_i[15:0];
                end else begin
                    rdata_d = {16'h0000, ctrl2_q};
                end
            end else if (paddr_i == pelf_pkg::STAT_OFS) begin
                // effective modes of pins 7..0 plus debug state, read only
                rdata_d = {15'h0000, dbg_q, eff_mode[15:0]};
                err_d = pwrite_i;
            end else begin
                err_d = 1'b1; // unmapped
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ctrl1_q <= pelf_pkg::CTRL_1_RST;
            ctrl2_q <= pelf_pkg::CTRL_2_RST;
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            err_q <= 1'b0;
            bus_q <= pelf_pkg::PELF_IDLE;
            dbg_q <= 1'b0;
        end else if (clk_en_i) begin
            ctrl1_q <= ctrl1_d;
            ctrl2_q <= ctrl2_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q <= err_d;
            bus_q <= bus_d;
            dbg_q <= dbg_d;
        end
    end
    assign prdata_o = rdata_q;
    assign pready_o = ready_q;
    assign pslverr_o = err_q;

    // ------------------------------------------------------------
    // per pin choice tables
    // ------------------------------------------------------------
    logic [3:0] c_out [12];
    logic [3:0] c_oe [12];
    logic [3:0] c_in [12];
    logic [11:0] p_out, p_oe;
    logic [11:0] pin_out_q, pin_oe_q;
    logic scan_force;
    assign scan_force = dbg_q && flash_variant_i;

    // code 3 on pins 6..0 selects trace only on flash
    always_comb begin
        for (int n = 0; n < pelf_pkg::PIN_N; n++) begin
            c_out[n][0] = gport_out_i[n];
            c_oe[n][0] = gport_oe_i[n];
            c_out[n][1] = timer_out_i[n];
            c_oe[n][1] = timer_oe_i[n];
            c_out[n][3:2] = 2'b00;
            c_oe[n][3:2] = 2'b00;
        end
        c_out[10][2] = serial2_transmit_i;
        c_oe[10][2] = 1'b1;
        c_out[9][3] = serial3_clock_out_i;
        c_oe[9][3] = serial3_clock_oe_i;
        c_out[8][2] = serial2_clock_out_i;
        c_oe[8][2] = serial2_clock_oe_i;
        c_out[6][2] = serial3_clock_out_i;
        c_oe[6][2] = serial3_clock_oe_i;
        c_out[5][2] = serial3_transmit_i;
        c_oe[5][2] = 1'b1;
        c_out[3][2] = dma1_acknowledge_i;
        c_oe[3][2] = 1'b1;
        c_out[1][2] = dma0_acknowledge_i;
        c_oe[1][2] = 1'b1;
        for (int n = 3; n <= 6; n++) begin
            c_out[n][3] = trace_data_out_i[6 - n] & flash_variant_i;
            c_oe[n][3] = trace_data_oe_i[6 - n] & flash_variant_i;
        end
        c_out[0][3] = trace_clock_out_i & flash_variant_i;
        c_oe[0][3] = trace_clock_oe_i & flash_variant_i;
    end

    // one cell per pin; debug mode on flash parts overrides pins 11..8
    genvar g;
    generate
        for (g = 0; g < pelf_pkg::PIN_N; g++) begin : g_pin
            logic [1:0] m;
            assign m = pin_mode(ctrl1_q, ctrl2_q, g);
            assign eff_mode[g * 2 +: 2] = m;
            pelf_pin_cell u_cell (
                .mode_i(m),
                .alt_out_i(c_out[g]),
                .alt_oe_i(c_oe[g]),
                .pin_in_i(port_pin_in_i[g]),
                .alt_in_o(c_in[g]),
                .pin_out_o(p_out[g]),
                .pin_oe_o(p_oe[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // input routing
    // ------------------------------------------------------------
    // shared inputs combine: serial receive and clock or, dma and trace
    // reset/clock and, as when one function sits on several pins
    logic [11:0] gin_d, tin_d;
    logic s3rx_d, s3ck_d, s2rx_d, s2ck_d, d1rq_d, d0rq_d;
    logic [3:0] trd_d;
    logic trst_d, trmd_d, trck_d, tdi_d, trs_d, tms_d;
    always_comb begin
        for (int n = 0; n < pelf_pkg::PIN_N; n++) begin
            gin_d[n] = c_in[n][0];
            tin_d[n] = c_in[n][1];
        end
        s3rx_d = (!scan_force && c_in[11][3]) ||
                 c_in[4][2];
        s3ck_d = (!scan_force && c_in[9][3]) || c_in[6][2];
        s2rx_d = c_in[7][2];
        s2ck_d = !scan_force && c_in[8][2];
        d1rq_d = (eff_mode[5:4] == pelf_pkg::MODE_ALT2) ?
                 port_pin_in_i[2] : 1'b1;
        d0rq_d = (eff_mode[1:0] == pelf_pkg::MODE_ALT2) ?
                 port_pin_in_i[0] : 1'b1;
        for (int n = 3; n <= 6; n++) begin
            trd_d[6 - n] = c_in[n][3] & flash_variant_i;
        end
        trst_d = !flash_variant_i ||
                 (eff_mode[5:4] != pelf_pkg::MODE_ALT3) ||
                 port_pin_in_i[2];
        trmd_d = flash_variant_i && c_in[1][3];
        trck_d = !flash_variant_i ||
                 (eff_mode[1:0] != pelf_pkg::MODE_ALT3) ||
                 port_pin_in_i[0];
        tdi_d = scan_force ? port_pin_in_i[10] : 1'b1;
        trs_d = scan_force ? port_pin_in_i[9] : 1'b1;
        tms_d = scan_force ? port_pin_in_i[8] : 1'b1;
        if (scan_force) begin
            gin_d[11:8] = 4'h0;
            tin_d[11:8] = 4'h0;
        end
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            pin_out_q <= 12'h000;
            pin_oe_q <= 12'h000;
            gport_in_o <= 12'h000;
            timer_in_o <= 12'h000;
            serial3_receive_o <= 1'b0;
            serial3_clock_in_o <= 1'b0;
            serial2_receive_o <= 1'b0;
            serial2_clock_in_o <= 1'b0;
            dma1_request_o <= 1'b1;
            dma0_request_o <= 1'b1;
            trace_data_in_o <= 4'h0;
            trace_reset_o <= 1'b1;
            trace_mode_sel_o <= 1'b0;
            trace_clock_in_o <= 1'b1;
            scan_tdi_o <= 1'b1;
            scan_trst_o <= 1'b1;
            scan_tms_o <= 1'b1;
        end else if (clk_en_i) begin
            pin_out_q <= p_out;
            pin_oe_q <= p_oe;
            if (scan_force) begin
                // pin 11 drives scan out, 10..8 are inputs
                pin_out_q[11:8] <= {scan_tdo_i, 3'b000};
                pin_oe_q[11:8] <= 4'b1000;
            end
            gport_in_o <= gin_d;
            timer_in_o <= tin_d;
            serial3_receive_o <= s3rx_d;
            serial3_clock_in_o <= s3ck_d;
            serial2_receive_o <= s2rx_d;
            serial2_clock_in_o <= s2ck_d;
            dma1_request_o <= d1rq_d;
            dma0_request_o <= d0rq_d;
            trace_data_in_o <= trd_d;
            trace_reset_o <= trst_d;
            trace_mode_sel_o <= trmd_d;
            trace_clock_in_o <= trck_d;
            scan_tdi_o <= tdi_d;
            scan_trst_o <= trs_d;
            scan_tms_o <= tms_d;
        end
    end
    assign port_pin_out_o = pin_out_q;
    assign port_pin_oe_o = pin_oe_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    scan_tdo_drive_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        clk_en_i && scan_force |=> port_pin_oe_o[11] && !port_pin_oe_o[10]
        && port_pin_out_o[11] == $past(scan_tdo_i))
        else $error("scan pin 11 not driven");
    pin0_timer_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        clk_en_i && ctrl2_q[1:0] == pelf_pkg::MODE_TIMER |=>
        port_pin_out_o[0] == $past(timer_out_i[0]))
        else $error("pin 0 timer output lost");
    pin10_serial_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        clk_en_i && !scan_force && ctrl1_q[5:4] == pelf_pkg::MODE_ALT2 |=>
        port_pin_oe_o[10] && port_pin_out_o[10] == $past(serial2_transmit_i))
        else $error("pin 10 serial2 transmit lost");
    pin3_dma_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        clk_en_i && ctrl2_q[7:6] == pelf_pkg::MODE_ALT2 |=>
        port_pin_out_o[3] == $past(dma1_acknowledge_i))
        else $error("pin 3 dma ack lost");
    pin7_rx_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        clk_en_i && ctrl2_q[15:14] == pelf_pkg::MODE_ALT2 |=>
        serial2_receive_o == $past(port_pin_in_i[7]))
        else $error("pin 7 receive lost");
    port_mode_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        clk_en_i && ctrl2_q[9:8] == pelf_pkg::MODE_PORT |=>
        gport_in_o[4] == $past(port_pin_in_i[4])
        && port_pin_oe_o[4] == $past(gport_oe_i[4]))
        else $error("pin 4 port path lost");
    pin5_trace_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        clk_en_i && ctrl2_q[11:10] == pelf_pkg::MODE_ALT3 |=>
        port_pin_oe_o[5] == $past(trace_data_oe_i[1] & flash_variant_i))
        else $error("pin 5 trace enable wrong");
    apb_answer_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        clk_en_i && access |=> pready_o)
        else $error("apb access not answered");
endmodule

// File: pkg/pelf_pkg.sv
// pelf_pkg: register map, field layout and mode codes of the port e low
// pin function select block.
// assumes: 32-bit apb slave, one aligned word per register.
package pelf_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_1_OFS = 8'h00; // pins 11 to 8
    localparam logic [7:0] CTRL_2_OFS = 8'h04; // pins 7 to 0
    localparam logic [7:0] STAT_OFS = 8'h08; // effective modes
    localparam logic [15:0] CTRL_1_RST = 16'h0000;
    localparam logic [15:0] CTRL_2_RST = 16'h0000;
    localparam logic [15:0] CTRL_1_MASK = 16'h00FF; // upper pins absent
    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int FIELD_W = 2; // width of one mode field
    localparam int PIN_N = 12; // pins handled
    localparam int PINS_PER_REG = 8; // fields in a 16-bit register
    // ------------------------------------------------------------
    // mode codes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_PORT = 2'h0;
    localparam logic [1:0] MODE_TIMER = 2'h1;
    localparam logic [1:0] MODE_ALT2 = 2'h2;
    localparam logic [1:0] MODE_ALT3 = 2'h3;
    // ------------------------------------------------------------
    // bus answer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PELF_IDLE = 2'b00,
        PELF_DONE = 2'b01
    } pelf_bus_e;
endpackage

// File: core/pelf_pin_cell.sv
// pelf_pin_cell: routes one pin among port, timer and two alternates.
// assumes: peripheral signals given as in/out/enable triples per choice.
`timescale 1ns/1ps
module pelf_pin_cell (
    input wire logic [1:0] mode_i, // effective mode code
    input wire logic [3:0] alt_out_i, // output per code
    input wire logic [3:0] alt_oe_i, // output enable per code
    input wire logic pin_in_i, // pin level
    output logic [3:0] alt_in_o, // pin level gated per code
    output logic pin_out_o, // selected output
    output logic pin_oe_o // selected enable
);
    // ------------------------------------------------------------
    // selection
    // ------------------------------------------------------------
    // pick the source for the chosen code; unselected inputs read 0
    always_comb begin
        alt_in_o = 4'h0;
        alt_in_o[mode_i] = pin_in_i;
        pin_out_o = alt_out_i[mode_i];
        pin_oe_o = alt_oe_i[mode_i];
    end
endmodule

// File: test/pelf_periph_model.sv
// pelf_periph_model: stand-in for the port, timer, serial, dma, trace and
// scan units that drive the pin function select block.
// assumes: the bench strobes step_i with a fresh pattern word.
`timescale 1ns/1ps
module pelf_periph_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic step_i,
    input wire logic [31:0] pat_i,
    output logic [66:0] drive_o
);
    logic [66:0] drive_q; // all unit outputs, packed
    logic [66:0] drive_d; // next value
    // shift each new word in, so every field keeps changing
    always_comb begin
        drive_d = drive_q;
        if (step_i) begin
            drive_d = {drive_q[34:0], pat_i};
        end
    end
    // units come out of reset with nothing driven
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            drive_q <= '0;
        end else begin
            drive_q <= drive_d;
        end
    end
    assign drive_o = drive_q;
endmodule

// File: test/pelf_top_test.sv
// pelf_top_test: self-checking bench for the pin function select block.
// assumes: pelf_pkg and pelf_periph_model compiled first.
`timescale 1ns/1ps
module pelf_top_test;
    logic clk_i, rst_b_i, clk_en_i, psel_i, penable_i, pwrite_i;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic pready_o, pslverr_o, flash_variant_i, debug_mode_pin_i;
    logic [11:0] port_pin_in_i, port_pin_out_o, port_pin_oe_o;
    logic [11:0] gport_out_i, gport_oe_i, gport_in_o;
    logic [11:0] timer_out_i, timer_oe_i, timer_in_o;
    logic serial3_receive_o, serial3_transmit_i, serial3_clock_out_i;
    logic serial3_clock_oe_i, serial3_clock_in_o, serial2_receive_o;
    logic serial2_transmit_i, serial2_clock_out_i, serial2_clock_oe_i;
    logic serial2_clock_in_o, dma1_acknowledge_i, dma0_acknowledge_i;
    logic dma1_request_o, dma0_request_o, trace_reset_o, trace_mode_sel_o;
    logic [3:0] trace_data_out_i, trace_data_oe_i, trace_data_in_o;
    logic trace_clock_out_i, trace_clock_oe_i, trace_clock_in_o;
    logic scan_tdo_i, scan_tdi_o, scan_trst_o, scan_tms_o;
    logic step;
    logic [31:0] pat, seed, r, v;
    logic e;
    logic [66:0] drive;
    logic [15:0] pin_fn; // unit inputs as seen from the pins
    int error_cnt = 0;
    int check_count = 0;
    // output and input source per pin, codes 10 and 11
    localparam int OSRC [24] = '{0, 11, 6, 0, 0, 0, 5, 10, 0, 9, 2, 8,
                                 3, 7, 0, 0, 4, 0, 0, 3, 1, 0, 0, 0};
    localparam int ISRC [24] = '{5, 12, -1, 11, 4, 10, -1, 9, 0, 8, -1, 7,
                                 1, 6, 2, -1, 3, -1, -1, 1, -1, -1, -1, 0};
    localparam logic [15:0] FN_IDLE = 16'hF430; // idle levels
    assign {gport_out_i, gport_oe_i, timer_out_i, timer_oe_i,
            serial3_transmit_i, serial3_clock_out_i, serial3_clock_oe_i,
            serial2_transmit_i, serial2_clock_out_i, serial2_clock_oe_i,
            dma1_acknowledge_i, dma0_acknowledge_i, trace_data_out_i,
            trace_data_oe_i, trace_clock_out_i, trace_clock_oe_i,
            scan_tdo_i} = drive;
    assign pin_fn = {scan_tms_o, scan_trst_o, scan_tdi_o, trace_clock_in_o,
                     trace_mode_sel_o, trace_reset_o, trace_data_in_o,
                     dma0_request_o, dma1_request_o, serial2_clock_in_o,
                     serial2_receive_o, serial3_clock_in_o,
                     serial3_receive_o};
    pelf_top pelf_top_inst (.*);
    pelf_periph_model pelf_periph_model_inst (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .step_i(step),
        .pat_i(pat),
        .drive_o(drive)
    );
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected {oe, out} of pin n under code c
    function automatic logic [1:0] exp_pin(int n, int c, logic f);
        int s;
        s = (c < 2) ? 0 : OSRC[2*n+c-2];
        if (c == 3 && !f && n < 7) s = 0;
        if (c == 0) return {gport_oe_i[n], gport_out_i[n]};
        if (c == 1) return {timer_oe_i[n], timer_out_i[n]};
        case (s)
            1: return {1'b1, serial2_transmit_i};
            2: return {1'b1, serial3_transmit_i};
            3: return {serial3_clock_oe_i, serial3_clock_out_i};
            4: return {serial2_clock_oe_i, serial2_clock_out_i};
            5: return {1'b1, dma1_acknowledge_i};
            6: return {1'b1, dma0_acknowledge_i};
            11: return {trace_clock_oe_i, trace_clock_out_i};
            default: return (s > 6) ?
                {trace_data_oe_i[s-7], trace_data_out_i[s-7]} : 2'b00;
        endcase
    endfunction
    // software keeps trace codes off parts without flash
    function automatic logic [15:0] no_trace(logic [15:0] c, logic f);
        for (int k = 0; k < 7; k++) begin
            if (!f && c[2*k +: 2] == 2'b11) begin
                c[2*k +: 2] = 2'b00;
            end
        end
        return c;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic chk_pin(input logic [15:0] g, input logic [15:0] x);
        chk({16'h0000, g}, {16'h0000, x});
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // program both fields, stir the units and pins, check every route
    task automatic run_cfg(input logic [15:0] c1, input logic [15:0] c2,
                           input logic f, input logic d);
        logic [11:0] eoe, eout, egp, etm;
        logic [15:0] efn;
        logic [1:0] po;
        logic p;
        int m, s;
        c2 = no_trace(c2, f);
        flash_variant_i <= f;
        debug_mode_pin_i <= d;
        apb(1'b1, pelf_pkg::CTRL_1_OFS, {16'hA5A5, c1});
        apb(1'b1, pelf_pkg::CTRL_2_OFS, {16'h5A5A, c2});
        apb(1'b0, pelf_pkg::CTRL_1_OFS, 32'h00000000);
        chk(r, {16'h0000, c1 & pelf_pkg::CTRL_1_MASK});
        apb(1'b0, pelf_pkg::CTRL_2_OFS, 32'h00000000);
        chk(r, {16'h0000, c2});
        apb(1'b0, pelf_pkg::STAT_OFS, 32'h00000000);
        chk(r, {15'h0000, d, c2});
        chk({31'h0, e}, 32'h00000000);
        seed = lfsr(seed);
        pat <= seed;
        seed = lfsr(seed);
        port_pin_in_i <= seed[11:0];
        step <= 1'b1;
        @(posedge clk_i);
        step <= 1'b0;
        repeat (3) @(posedge clk_i);
        efn = FN_IDLE;
        for (int k = 0; k < 12; k++) begin
            m = (k > 7) ? c1[2*k-16 +: 2] : c2[2*k +: 2];
            p = port_pin_in_i[k];
            s = (m < 2) ? -1 : ISRC[2*k+m-2];
            if (m == 3 && !f && k < 7) s = -1;
            po = exp_pin(k, m, f);
            if (f && d && k > 7) begin
                m = 4;
                s = (k == 11) ? -1 : 23 - k;
                po = (k == 11) ? {1'b1, scan_tdo_i} : 2'b00;
            end
            {eoe[k], eout[k]} = po;
            egp[k] = (m == 0) & p;
            etm[k] = (m == 1) & p;
            if (s >= 0) efn[s] = FN_IDLE[s] ? efn[s] & p : efn[s] | p;
        end
        chk_pin({4'h0, port_pin_oe_o}, {4'h0, eoe});
        chk_pin({4'h0, port_pin_out_o}, {4'h0, eout});
        chk_pin({4'h0, gport_in_o}, {4'h0, egp});
        chk_pin({4'h0, timer_in_o}, {4'h0, etm});
        chk_pin(pin_fn, efn);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // clock, watchdog, main sequence
    // ----------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        conclude();
    end
    initial begin
        {rst_b_i, psel_i, penable_i, pwrite_i, step} = '0;
        {paddr_i, pwdata_i, pat, port_pin_in_i} = '0;
        {flash_variant_i, debug_mode_pin_i} = '0;
        clk_en_i = 1'b1;
        seed = 32'h00001403;
        repeat (5) @(posedge clk_i);
        chk_pin({4'h0, port_pin_oe_o}, 16'h0000);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        apb(1'b0, pelf_pkg::CTRL_1_OFS, 32'h00000000);
        chk(r, {16'h0000, pelf_pkg::CTRL_1_RST});
        apb(1'b0, pelf_pkg::CTRL_2_OFS, 32'h00000000);
        chk(r, {16'h0000, pelf_pkg::CTRL_2_RST});
        // unmapped read and status write are refused
        apb(1'b0, 8'h0C, 32'h00000000);
        chk({31'h0, e}, 32'h00000001);
        chk(r, 32'h00000000);
        apb(1'b1, pelf_pkg::STAT_OFS, 32'h0000FFFF);
        chk({31'h0, e}, 32'h00000001);
        // every code on every pin, both variants, except code 3 on pins 6..0 without flash
        for (int f = 0; f < 2; f++) begin
            for (int n = 0; n < 12; n++) begin
                for (int c = 0; c < 4; c++) begin
                    v = 32'(c) << (2 * n);
                    run_cfg(v[31:16], v[15:0], f[0], 1'b0);
                end
            end
        end
        // debug override, then without flash it must not act
        run_cfg(16'h00FF, 16'hFFFF, 1'b1, 1'b1);
        run_cfg(16'h0055, 16'h0000, 1'b0, 1'b1);
        run_cfg(16'h00C3, 16'h0000, 1'b1, 1'b0);
        // low clock enable must freeze gport_in_o and port_pin_out_o
        v = {8'h00, gport_in_o, port_pin_out_o};
        seed = lfsr(seed);
        clk_en_i <= 1'b0;
        port_pin_in_i <= ~port_pin_in_i;
        pat <= seed;
        step <= 1'b1;
        @(posedge clk_i);
        step <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk({8'h00, gport_in_o, port_pin_out_o}, v);
        clk_en_i <= 1'b1;
        repeat (60) begin
            seed = lfsr(seed);
            v = seed;
            seed = lfsr(seed);
            run_cfg(v[15:0], v[31:16], seed[0], seed[1] & seed[2]);
        end
        conclude();
    end
endmodule
